// ### rtl/dac_params.svh
/*
 Constants of the dual converter serial control: address, pulse counts,
 command codes and reset values. Assumes inclusion by bare name.
*/
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH
// Fixed upper five bits of the two-wire target address
`define ADDR_FIXED      5'h0C
// Two-wire pulse numbers within one write transaction
`define TW_ADDR_PULSE   5'h08
`define TW_CMD_FIRST    5'h0A
`define TW_CMD_LAST     5'h11
`define TW_DATA_FIRST   5'h13
`define TW_EXEC_PULSE   5'h1A
`define TW_LAST_PULSE   5'h1B
// Shift-register frame length in clocks
`define SPI_FRAME       5'h10
// Edges after reset release before the strap level reaches the logic
`define STRAP_SETTLE    2'h2
// Synchroniser idle pattern: mode 0, straps 0, scl and sda high,
// sclk low, cs_n high, din low
`define SYNC_IDLE       8'h1A
// Command codes
`define CMD_NOP         6'h00
`define CMD_LOAD_BOTH   6'h01
`define CMD_LOAD_A      6'h02
`define CMD_LOAD_B      6'h03
`define CMD_IN_BOTH     6'h04
`define CMD_IN_A        6'h05
`define CMD_IN_B        6'h06
`define CMD_UPD_BOTH    6'h07
`define CMD_UPD_A       6'h09
`define CMD_UPD_B       6'h0A
`define CMD_REF_INT     6'h0B
`define CMD_REF_EXT     6'h0C
`define CMD_SHDN_BOTH   6'h0D
`define CMD_SHDN_A      6'h0E
`define CMD_SHDN_B      6'h0F
`define CMD_PWR_BOTH    6'h2D
`define CMD_PWR_A       6'h2E
`define CMD_PWR_B       6'h2F
// Range groups: upper three command bits, lower three pick the range
`define RANGE_A_GRP     3'h2
`define RANGE_B_GRP     3'h6
`define RANGE_TOP       3'h5
// Reset values
`define RST_VALUE       10'h000
`define RST_RANGE       3'h0
`define RST_EXT_REF     1'b1
`define RST_SHDN        1'b0
`endif

// ### rtl/dac_pkg.sv
/*
 Types shared by the converter control modules.
 Assumes the constants header for all numeric values.
*/
package dac_pkg;
   // Two-wire transaction phase
   typedef enum logic [1:0] {
      TW_IDLE   = 2'b00,
      TW_ACTIVE = 2'b01,
      TW_IGNORE = 2'b10
   } tw_state_e;
   // Full-scale range selector
   typedef logic [2:0] range_t;
endpackage : dac_pkg

// ### rtl/sync2.sv
/*
 Two flip-flop synchroniser for a group of independent levels.
 Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   input  wire logic [WIDTH-1:0] rst_val,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;  // First stage, read only by the second
   logic [WIDTH-1:0] held;  // Second stage

   // Both stages hold the level relative to rst_val, so a plain zero
   // reset stands for the idle pattern at either stage; q then shows
   // the idle levels during reset, not all zeros
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta <= '0;
         held <= '0;
      end else begin
         meta <= d ^ rst_val;
         held <= meta;
      end
   end

   // Undo the offset; rst_val is a constant at the instance
   assign q = held ^ rst_val;
endmodule : sync2

// ### rtl/cmd_decoder.sv
/*
 Command decoder and converter register bank for both channels.
 Assumes exec is a one-cycle pulse carrying a stable command and value.
*/
`timescale 1ns/10ps
`include "dac_params.svh"
module cmd_decoder (
   input  wire logic          ref_clk,
   input  wire logic          reset,
   input  wire logic          exec,
   input  wire logic [5:0]    cmd,
   input  wire logic [9:0]    value,
   output logic      [9:0]    in_value_a,
   output logic      [9:0]    in_value_b,
   output logic      [9:0]    out_value_a,
   output logic      [9:0]    out_value_b,
   output logic               ext_ref_sel,
   output logic               shutdown_a,
   output logic               shutdown_b,
   output dac_pkg::range_t    range_a,
   output dac_pkg::range_t    range_b
);
   // Decoded strobes; unlisted codes hit none of them
   wire is_ld_both = (cmd == `CMD_LOAD_BOTH);
   wire ld_in_a    = exec & (is_ld_both | cmd == `CMD_LOAD_A | cmd == `CMD_IN_BOTH
                            | cmd == `CMD_IN_A);
   wire ld_in_b    = exec & (is_ld_both | cmd == `CMD_LOAD_B | cmd == `CMD_IN_BOTH
                            | cmd == `CMD_IN_B);
   wire ld_out_a   = exec & (is_ld_both | cmd == `CMD_LOAD_A);
   wire ld_out_b   = exec & (is_ld_both | cmd == `CMD_LOAD_B);
   wire cp_out_a   = exec & (cmd == `CMD_UPD_BOTH | cmd == `CMD_UPD_A);
   wire cp_out_b   = exec & (cmd == `CMD_UPD_BOTH | cmd == `CMD_UPD_B);
   wire ref_int    = exec & (cmd == `CMD_REF_INT);
   wire ref_ext    = exec & (cmd == `CMD_REF_EXT);
   wire shdn_a     = exec & (cmd == `CMD_SHDN_BOTH | cmd == `CMD_SHDN_A);
   wire shdn_b     = exec & (cmd == `CMD_SHDN_BOTH | cmd == `CMD_SHDN_B);
   wire pwr_a      = exec & (cmd == `CMD_PWR_BOTH | cmd == `CMD_PWR_A);
   wire pwr_b      = exec & (cmd == `CMD_PWR_BOTH | cmd == `CMD_PWR_B);
   wire rng_ok     = (cmd[2:0] <= `RANGE_TOP);
   wire rng_a      = exec & rng_ok & (cmd[5:3] == `RANGE_A_GRP);
   wire rng_b      = exec & rng_ok & (cmd[5:3] == `RANGE_B_GRP);

   // Register bank; reset stands for a supply cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         in_value_a  <= `RST_VALUE;
         in_value_b  <= `RST_VALUE;
         out_value_a <= `RST_VALUE;
         out_value_b <= `RST_VALUE;
         ext_ref_sel <= `RST_EXT_REF;
         shutdown_a  <= `RST_SHDN;
         shutdown_b  <= `RST_SHDN;
         range_a     <= `RST_RANGE;
         range_b     <= `RST_RANGE;
      end else begin
         if (ld_in_a) in_value_a <= value;
         if (ld_in_b) in_value_b <= value;
         // Output copy reads the input register before any load this cycle
         if (ld_out_a) out_value_a <= value;
         else if (cp_out_a) out_value_a <= in_value_a;
         if (ld_out_b) out_value_b <= value;
         else if (cp_out_b) out_value_b <= in_value_b;
         if (ref_int) ext_ref_sel <= 1'b0;
         else if (ref_ext) ext_ref_sel <= 1'b1;
         // Shutdown gates outputs only; loads above stay live
         if (shdn_a) shutdown_a <= 1'b1;
         else if (pwr_a) shutdown_a <= 1'b0;
         if (shdn_b) shutdown_b <= 1'b1;
         else if (pwr_b) shutdown_b <= 1'b0;
         if (rng_a) range_a <= cmd[2:0];
         if (rng_b) range_b <= cmd[2:0];
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_nop_holds_all: assert property (
      exec && cmd == `CMD_NOP |=> $stable(out_value_a) && $stable(in_value_b)
                                  && $stable(range_a))
      else $error("no-op changed state");
   a_unlisted_holds: assert property (
      exec && cmd == 6'h08 |=> $stable(in_value_a) && $stable(out_value_b)
                               && $stable(ext_ref_sel) && $stable(shutdown_a))
      else $error("unlisted code changed state");
   a_copy_out_a: assert property (
      exec && cmd == `CMD_UPD_A |=> out_value_a == $past(in_value_a)
                                    && $stable(out_value_b))
      else $error("output copy wrong");
   a_range_b_set: assert property (
      exec && cmd == 6'h34 |=> range_b == 3'h4 && $stable(range_a))
      else $error("range b not set");
   a_shdn_keeps_load: assert property (
      shutdown_a && exec && cmd == `CMD_IN_A |=> in_value_a == $past(value))
      else $error("load blocked in shutdown");
endmodule : cmd_decoder

// ### rtl/dual_dac_serial_control.sv
/*
 Serial control of a dual 10-bit converter: strap-selected two-wire
 write interface or three-wire shift interface with chained output,
 feeding one command decoder. Assumes all pins are asynchronous to
 ref_clk and that serial clocks run well below ref_clk / 8.
*/
`timescale 1ns/10ps
`include "dac_params.svh"
module dual_dac_serial_control (
   input  wire logic          ref_clk,
   input  wire logic          reset,
   input  wire logic          mode_sel,
   input  wire logic          addr_strap_hi,
   input  wire logic          addr_strap_lo,
   input  wire logic          scl,
   input  wire logic          sda_in,
   output logic               sda_out,
   output logic               sda_oe,
   input  wire logic          sclk,
   input  wire logic          cs_n,
   input  wire logic          din,
   output logic               dout,
   output logic               dout_oe,
   output logic [9:0]         in_value_a,
   output logic [9:0]         in_value_b,
   output logic [9:0]         out_value_a,
   output logic [9:0]         out_value_b,
   output logic               ext_ref_sel,
   output logic               shutdown_a,
   output logic               shutdown_b,
   output dac_pkg::range_t    range_a,
   output dac_pkg::range_t    range_b
);
   // Synchronised pins; idle-high lines reset high
   logic                s_mode;          // Interface strap level
   logic                s_a1;            // Address strap, upper
   logic                s_a0;            // Address strap, lower
   logic                s_scl;           // Two-wire clock
   logic                s_sda;           // Two-wire data
   logic                s_sclk;          // Shift clock
   logic                s_cs_n;          // Shift select, low active
   logic                s_din;           // Shift data in
   // Previous synchronised values for edge finding
   logic                scl_q;
   logic                sda_q;
   logic                sclk_q;
   logic                cs_n_q;
   // Strap capture; the wait lets the synchroniser fill with the pin level
   logic [1:0]          strap_age;       // Edges since reset release
   logic                mode_caught;     // Strap taken once after release
   logic                mode_spi;        // High selects shift interface
   // Two-wire state
   dac_pkg::tw_state_e  tw_state;        // Transaction phase
   logic [4:0]          pulse_cnt;       // Clock pulses since start
   logic [7:0]          addr_byte;       // Address byte as received
   logic [15:0]         tw_shift;        // Command and data bits
   logic                start_in_high;   // Start seen in this high phase
   // Shift interface state
   logic [4:0]          spi_cnt;         // Bits in frame, saturates
   logic [15:0]         spi_shift;       // Frame shift register
   logic                spill;           // Bit just pushed out of the top

   // All eight pins through one synchroniser; first stage hidden inside
   sync2 #(
      .WIDTH   (8)
   ) u_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .d       ({mode_sel, addr_strap_hi, addr_strap_lo, scl, sda_in,
                 sclk, cs_n, din}),
      .rst_val (`SYNC_IDLE),
      .q       ({s_mode, s_a1, s_a0, s_scl, s_sda, s_sclk, s_cs_n, s_din})
   );

   // Edge and condition decode
   wire scl_rise  = s_scl & ~scl_q;
   wire scl_fall  = ~s_scl & scl_q;
   wire tw_start  = scl_q & s_scl & sda_q & ~s_sda;
   wire tw_stop   = scl_q & s_scl & ~sda_q & s_sda;
   wire sclk_rise = s_sclk & ~sclk_q;
   wire sclk_fall = ~s_sclk & sclk_q;
   wire cs_rise   = s_cs_n & ~cs_n_q;
   // Unused interface ignores its pins entirely
   wire tw_en     = mode_caught & ~mode_spi;
   wire spi_en    = mode_caught & mode_spi;

   // Two-wire decode
   wire [4:0]  pulse_num  = pulse_cnt + 5'h01;
   wire [4:0]  next_pulse = (pulse_cnt == `TW_LAST_PULSE) ? pulse_cnt : pulse_num;
   wire [7:0]  addr_full  = {addr_byte[6:0], s_sda};
   wire        addr_hit   = (addr_full[7:1] == {`ADDR_FIXED, s_a1, s_a0})
                            & ~addr_full[0];
   wire        is_addr_bit = (pulse_num <= `TW_ADDR_PULSE);
   wire        is_data_bit = ((pulse_num >= `TW_CMD_FIRST) & (pulse_num <= `TW_CMD_LAST))
                             | ((pulse_num >= `TW_DATA_FIRST)
                                & (pulse_num <= `TW_EXEC_PULSE));
   wire        tw_busy    = (tw_state == dac_pkg::TW_ACTIVE);
   wire        stop_ok    = tw_stop & ~start_in_high;
   // Ack windows open at the falling edge ending pulses 8, 17 and 26
   wire        ack_due    = tw_busy & ((pulse_cnt == `TW_ADDR_PULSE)
                            | (pulse_cnt == `TW_CMD_LAST)
                            | (pulse_cnt == `TW_EXEC_PULSE));
   wire [15:0] tw_word    = {tw_shift[14:0], s_sda};
   // Only the 26th rise of a live write executes; earlier stops never do
   wire        tw_exec    = tw_en & tw_busy & scl_rise & ~tw_start & ~stop_ok
                            & (pulse_num == `TW_EXEC_PULSE);

   // Shift interface decode
   wire        spi_exec   = spi_en & cs_rise & (spi_cnt == `SPI_FRAME);
   wire        spi_live   = spi_en & ~s_cs_n;
   wire [4:0]  next_spi   = (spi_cnt == `SPI_FRAME) ? spi_cnt : spi_cnt + 5'h01;

   // Command source: the two interfaces never run at once
   wire        exec       = tw_exec | spi_exec;
   wire [15:0] word       = spi_exec ? spi_shift : tw_word;

   // Edge history, idle-high lines reset high
   // Matching the synchroniser's idle pattern avoids a false edge at release
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         scl_q  <= s_scl;
         sda_q  <= s_sda;
         sclk_q <= s_sclk;
         cs_n_q <= s_cs_n;
      end
   end

   // Strap taken once after reset release, then held static
   // Both sync stages leave reset at the idle pattern, so the pin level
   // reaches s_mode only at the second edge after release; sampling it
   // earlier would always read two-wire mode
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         strap_age   <= 2'h0;
         mode_caught <= 1'b0;
         mode_spi    <= 1'b0;
      end else if (!mode_caught) begin
         if (strap_age == `STRAP_SETTLE) begin
            // Pin level now stands at the synchroniser output
            mode_caught <= 1'b1;
            mode_spi    <= s_mode;
         end else begin
            // Still the reset pattern at the synchroniser output
            strap_age   <= strap_age + 2'h1;
         end
      end
   end

   // Two-wire phase and pulse counting
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tw_state  <= dac_pkg::TW_IDLE;
         pulse_cnt <= 5'h00;
      end else if (!tw_en) begin
         tw_state  <= dac_pkg::TW_IDLE;
         pulse_cnt <= 5'h00;
      end else if (tw_start) begin
         // Fresh or repeated start both restart the write
         tw_state  <= dac_pkg::TW_ACTIVE;
         pulse_cnt <= 5'h00;
      end else if (stop_ok) begin
         tw_state  <= dac_pkg::TW_IDLE;
      end else if (scl_rise) begin
         unique case (tw_state)
            dac_pkg::TW_IDLE: begin
               pulse_cnt <= 5'h00;
            end
            dac_pkg::TW_ACTIVE: begin
               pulse_cnt <= next_pulse;
               // Foreign or read address: sit out until the next start
               if (pulse_num == `TW_ADDR_PULSE && !addr_hit)
                  tw_state <= dac_pkg::TW_IGNORE;
            end
            dac_pkg::TW_IGNORE: begin
               pulse_cnt <= next_pulse;
            end
            default: begin
               tw_state <= dac_pkg::TW_IDLE;
            end
         endcase
      end
   end

   // Two-wire bit capture; ack pulses are skipped
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         addr_byte <= 8'h00;
         tw_shift  <= 16'h0000;
      end else if (tw_en && tw_busy && scl_rise) begin
         if (is_addr_bit) addr_byte <= addr_full;
         else if (is_data_bit) tw_shift <= tw_word;
      end
   end

   // Marks a start so a stop in the same high phase is ignored
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         start_in_high <= 1'b0;
      end else if (tw_start) begin
         start_in_high <= 1'b1;
      end else if (scl_fall) begin
         start_in_high <= 1'b0;
      end
   end

   // Acknowledge drive: low from the fall before a ninth pulse to its fall
   // Only the enable moves; sda_out stays low as the pin is open drain
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else if (!tw_en || tw_start || stop_ok) begin
         sda_oe  <= 1'b0;
      end else if (scl_fall) begin
         sda_oe  <= ack_due;
      end
   end

   // Shift register; frames longer than 16 keep the last 16 bits
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         spi_cnt   <= 5'h00;
         spi_shift <= 16'h0000;
         spill     <= 1'b0;
      end else if (!spi_live) begin
         // Select high: interface idle, count restarts next frame
         spi_cnt   <= 5'h00;
      end else if (sclk_rise) begin
         spi_cnt   <= next_spi;
         spi_shift <= {spi_shift[14:0], s_din};
         spill     <= spi_shift[15];
      end
   end

   // Chained output: the spilled bit leaves on the following fall
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dout    <= 1'b0;
         dout_oe <= 1'b0;
      end else begin
         // Enable tracks the synchronised select, one cycle late
         dout_oe <= spi_live;
         if (spi_live && sclk_fall) dout <= spill;
      end
   end

   // One decoder serves both interfaces
   cmd_decoder u_dec (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .exec        (exec),
      .cmd         (word[15:10]),
      .value       (word[9:0]),
      .in_value_a  (in_value_a),
      .in_value_b  (in_value_b),
      .out_value_a (out_value_a),
      .out_value_b (out_value_b),
      .ext_ref_sel (ext_ref_sel),
      .shutdown_a  (shutdown_a),
      .shutdown_b  (shutdown_b),
      .range_a     (range_a),
      .range_b     (range_b)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Protocol checks; all sampled on ref_clk and quiet during reset
   a_ack_window: assert property (
      sda_oe |-> pulse_cnt inside {5'h08, 5'h09, 5'h11, 5'h12, 5'h1A, 5'h1B})
      else $error("ack drive outside ack pulse");
   a_addr_ack: assert property (
      tw_en && scl_fall && tw_busy && pulse_cnt == 5'h08 && !tw_start && !stop_ok
      |=> sda_oe ##1 sda_oe)
      else $error("matching address not acked");
   a_exec_address: assert property (
      tw_exec |-> addr_byte[7:1] == {5'h0C, s_a1, s_a0})
      else $error("executed for foreign address");
   a_read_no_ack: assert property (
      tw_en && scl_fall && pulse_cnt == 5'h08 && addr_byte[0] |=> !sda_oe)
      else $error("read address acked");
   a_exec_pulse: assert property (
      tw_exec |-> pulse_cnt == 5'h19 && tw_en)
      else $error("two-wire exec at wrong pulse");
   a_stop_aborts: assert property (
      tw_en && stop_ok && pulse_cnt <= 5'h19 |=> !tw_exec [*2])
      else $error("aborted write executed");
   a_spi_frame_exec: assert property (
      spi_exec |-> $past(spi_cnt) == 5'h10 && !$past(s_cs_n))
      else $error("shift exec without full frame");
   a_dout_float: assert property (
      s_cs_n |=> !dout_oe)
      else $error("chained output driven while deselected");
   a_spi_count: assert property (
      spi_live && sclk_rise && spi_cnt == 5'h0F |=> spi_cnt == 5'h10)
      else $error("frame count wrong");
   // Strap is static once taken; a later pin change must not switch modes
   a_strap_static: assert property (
      mode_caught |=> mode_caught && $stable(mode_spi))
      else $error("interface strap changed after capture");
   // In shift mode the two-wire side never answers nor executes
   a_tw_quiet_spi: assert property (
      spi_en |=> !sda_oe && !tw_exec)
      else $error("two-wire side active in shift mode");
   // Chained output only moves on a shift clock fall inside a frame
   a_dout_on_fall: assert property (
      !(spi_live && sclk_fall) |=> $stable(dout))
      else $error("chained output moved off a clock fall");

   c_tw_write: cover property (tw_exec);
   c_spi_write: cover property (spi_exec);
   c_rep_start: cover property (tw_busy && pulse_cnt > 5'h05 && tw_start);
   c_read_ignored: cover property (tw_state == dac_pkg::TW_IGNORE);
endmodule : dual_dac_serial_control

// ### dv/serial_master.sv
/* Serial master model: two-wire writes and shift frames.
   Assumes ref_clk paces it; the two-wire data wire has a pull-up. */
`timescale 1ns/10ps
module serial_master (
   input  wire logic ref_clk,
   input  wire logic sda_out,
   input  wire logic sda_oe,
   input  wire logic dout,
   input  wire logic dout_oe,
   output logic      scl,
   output logic      sda,
   output logic      sclk,
   output logic      cs_n,
   output logic      din
);
   logic pull_low;  // Master holds data low
   // Wired-AND of both parties, pull-up when released
   assign sda = !(pull_low || (sda_oe && !sda_out));
   // Idle: clocks still, select high
   initial {scl, pull_low, sclk, cs_n, din} = 5'h12;
   task automatic hc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : hc
   // Start, n pulses, one more clock rise, then stop or repeated start
   task automatic tw_xfer(input logic [7:0] a, input logic [15:0] w, input int n,
                          input logic stop, output logic [2:0] ack);
      logic [26:0] bits;
      bits = {a, 1'b1, w[15:8], 1'b1, w[7:0], 1'b1};
      ack = 3'h7;
      scl = 1'b1;
      hc(8);
      pull_low = 1'b1;  // Start edge
      hc(8);
      for (int i = 0; i < n; i++) begin
         scl = 1'b0;
         hc(4);
         pull_low = !bits[26-i];  // Data moves only while clock low
         hc(4);
         scl = 1'b1;
         hc(8);
         if (i % 9 == 8) ack[i/9] = sda;
      end
      scl = 1'b0;
      hc(4);
      pull_low = stop;
      hc(4);
      scl = 1'b1;
      hc(8);
      pull_low = 1'b0;  // Stop edge, if asked
      hc(8);
   endtask : tw_xfer
   // One shift frame of n clocks; q holds chained output bits
   task automatic spi_xfer(input logic [15:0] w, input int n,
                           output logic [15:0] q, output logic oe);
      q = 16'h0000;
      cs_n = 1'b0;
      hc(4);
      for (int i = 0; i < n; i++) begin
         din = w[15-i];
         hc(4);
         sclk = 1'b1;
         hc(8);
         sclk = 1'b0;
         hc(4);
         q[15-i] = dout_oe ? dout : !dout;  // Released line reads as the inverse
         oe = dout_oe;
      end
      din = !din;  // Stale level not left behind
      cs_n = 1'b1;
      hc(8);
   endtask : spi_xfer
endmodule : serial_master

// ### dv/dual_dac_serial_control_tb_top.sv
/* Self-checking bench of the dual converter serial control.
   Assumes design files and the master model compiled first. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module dual_dac_serial_control_tb_top;
   logic            ref_clk, reset, mode_sel, addr_strap_hi, addr_strap_lo;
   logic            scl, sda, sda_out, sda_oe, sclk, cs_n, din, dout, dout_oe;
   logic [9:0]      in_value_a, in_value_b, out_value_a, out_value_b;
   logic            ext_ref_sel, shutdown_a, shutdown_b;
   dac_pkg::range_t range_a, range_b;
   logic [2:0]      ack;            // Low = acknowledged
   logic [15:0]     q;              // Chained output of a frame
   logic            oe;             // Chained enable inside frame
   int              err_total = 0;
   int              n_checks = 0;
   localparam logic [7:0] ADDR_W = {5'h0C, 2'h2, 1'b0};  // Straps 1,0, write
   dual_dac_serial_control dut_u (.sda_in(sda), .*);
   serial_master master_u (.*);
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;
   // Reset stands for a supply cycle; strap steady across it
   task automatic hold_reset(input logic mode);
      reset = 1'b1;
      mode_sel = mode;
      repeat (12) @(negedge ref_clk);
      reset = 1'b0;
      repeat (8) @(negedge ref_clk);
   endtask : hold_reset
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic t_defaults;
      `CHK({out_value_a, out_value_b, in_value_a, in_value_b}, 40'h0)
      `CHK({ext_ref_sel, shutdown_a, shutdown_b, range_a, range_b}, 9'h100)
   endtask : t_defaults
   task automatic tw(input logic [7:0] a, input logic [15:0] w, input int n, input logic s);
      master_u.tw_xfer(a, w, n, s, ack);
      repeat (6) @(negedge ref_clk);
   endtask : tw
   // Good write, wrong address, read, stop after 25 and 26 rises, repeated start
   task automatic t_two_wire;
      tw(ADDR_W, {6'h01, 10'h2A5}, 27, 1'b1);
      `CHK(ack, 3'h0)
      `CHK({out_value_a, out_value_b}, 20'hA96A5)
      tw({5'h0C, 2'h0, 1'b0}, {6'h02, 10'h155}, 27, 1'b1);
      `CHK(ack, 3'h7)
      tw(ADDR_W | 8'h01, {6'h02, 10'h155}, 27, 1'b1);
      `CHK(ack, 3'h7)
      tw(ADDR_W, {6'h02, 10'h155}, 24, 1'b1);
      `CHK(out_value_a, 10'h2A5)
      tw(ADDR_W, {6'h02, 10'h154}, 25, 1'b1);
      `CHK(out_value_a, 10'h154)
      tw(ADDR_W, {6'h03, 10'h0F0}, 27, 1'b0);
      tw(ADDR_W, {6'h05, 10'h00F}, 27, 1'b1);
      `CHK({out_value_b, in_value_a}, 20'h3C00F)
   endtask : t_two_wire
   task automatic sx(input logic [5:0] c, input logic [9:0] v);
      master_u.spi_xfer({c, v}, 16, q, oe);
      repeat (6) @(negedge ref_clk);
   endtask : sx
   // Chained output, enable, two-wire ignored in shift mode
   task automatic t_chain;
      sx(6'h00, 10'h2B6);
      sx(6'h00, 10'h000);
      `CHK(q, 16'h02B6)
      `CHK({oe, dout_oe}, 2'h2)
      tw(ADDR_W, {6'h01, 10'h3FF}, 27, 1'b1);
      `CHK({ack, out_value_a}, 13'h1C00)
   endtask : t_chain
   task automatic t_loads;
      sx(6'h05, 10'h011);
      sx(6'h06, 10'h022);
      `CHK({in_value_a, in_value_b, out_value_a}, 30'h0110_8800)
      sx(6'h09, 10'h3FF);
      `CHK({out_value_a, out_value_b}, 20'h04400)
      sx(6'h0A, 10'h3FF);
      sx(6'h04, 10'h0AA);
      `CHK({out_value_b, in_value_a}, 20'h088AA)
      sx(6'h07, 10'h3FF);
      `CHK(out_value_b, 10'h0AA)
      sx(6'h02, 10'h123);
      sx(6'h03, 10'h321);
      sx(6'h00, 10'h3FF);
      sx(6'h08, 10'h3FF);
      sx(6'h3F, 10'h3FF);
      master_u.spi_xfer({6'h01, 10'h3FF}, 15, q, oe);
      `CHK({out_value_a, out_value_b}, 20'h48F21)
   endtask : t_loads
   task automatic t_modes;
      logic [5:0] codes [6] = '{6'h0D, 6'h2E, 6'h2F, 6'h0E, 6'h0F, 6'h2D};
      logic [1:0] want [6] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
      sx(6'h0B, 10'h000);
      `CHK(ext_ref_sel, 1'b0)
      sx(6'h0C, 10'h000);
      `CHK(ext_ref_sel, 1'b1)
      foreach (codes[i]) begin
         sx(codes[i], 10'h3FF);
         `CHK({shutdown_a, shutdown_b}, want[i])
      end
      for (int r = 5; r >= 0; r--) begin
         sx({3'h2, r[2:0]}, 10'h000);
         sx({3'h6, r[2:0]}, 10'h000);
         `CHK({range_a, range_b}, {r[2:0], r[2:0]})
      end
      sx(6'h16, 10'h000);
      `CHK(range_a, 3'h0)
      sx(6'h0E, 10'h000);
      sx(6'h05, 10'h2C3);
      `CHK({shutdown_a, in_value_a}, 11'h6C3)
   endtask : t_modes
   initial begin
      {addr_strap_hi, addr_strap_lo} = 2'h2;  // Straps 1,0 match ADDR_W
      hold_reset(1'b0);
      t_defaults();
      t_two_wire();
      hold_reset(1'b1);
      t_defaults();
      t_chain();
      t_loads();
      t_modes();
      test_done();
   end
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_total++;
      test_done();
   end
endmodule : dual_dac_serial_control_tb_top
